// ### bench/pmc_core_model.sv
// behavioural core event sources and time base facing the monitor
`timescale 1ns/1ps
`default_nettype none
module pmc_core_model
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [3:0] ev_en,
  input wire logic [63:0] tb_step,
  input wire logic tb_clr,
  output logic [3:0] event_hit,
  output logic [63:0] time_base
);
  integer seed = 32'h798e;
  // random events only on enabled lines, time base advances by a chosen step
  always @(posedge ref_clk)
  begin
    event_hit <= ev_en & 4'($random(seed));
    if (rst || tb_clr)
      time_base <= 64'h0000_0000_0000_0000;
    else
      time_base <= time_base + tb_step;
  end
endmodule
`default_nettype wire

// ### bench/test_pmc_monitor_control.sv
// self-checking bench for the performance monitor control block
`timescale 1ns/1ps
`default_nettype none
`include "pmc_regs.svh"
module test_pmc_monitor_control;
  import pmc_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  pmc_spr_req_t spr_req = '0;
  pmc_core_state_t core_state = '0;
  logic [3:0] ev_en = 4'h0;
  logic [63:0] tb_step = '0;
  logic tb_clr = 1'b0;
  logic counter2_count_control = 1'b0;
  logic [3:0] event_hit;
  logic [63:0] time_base;
  logic [31:0] spr_rdata;
  logic spr_rvalid;
  logic monitor_irq;
  logic irq_prev = 1'b0;
  logic [31:0] hits [0:3] = '{default: 32'h0000_0000};
  logic [9:0] cnum [0:3] = '{`PMC_SPR_COUNTER1, `PMC_SPR_COUNTER2, `PMC_SPR_COUNTER3, `PMC_SPR_COUNTER4};
  int fpos [0:9] = '{31, 0, 30, 30, 29, 29, 28, 28, 27, 27};
  logic [9:0] fuser = 10'h018;
  logic [9:0] fmark = 10'h240;
  logic [31:0] v;
  integer num_errors = 0;
  integer checks_done = 0;
  integer seed = 32'h798e;
  integer irq_cnt = 0;

  pmc_core_model core_u (.ref_clk(ref_clk), .rst(rst), .ev_en(ev_en), .tb_step(tb_step),
    .tb_clr(tb_clr), .event_hit(event_hit), .time_base(time_base));
  pmc_monitor_control dut_u (.ref_clk(ref_clk), .rst(rst), .spr_req(spr_req), .core_state(core_state),
    .event_hit(event_hit), .time_base(time_base), .counter2_count_control(counter2_count_control),
    .spr_rdata(spr_rdata), .spr_rvalid(spr_rvalid), .monitor_irq(monitor_irq));

  always #20 ref_clk = ~ref_clk;

  task automatic fail(input string msg);
    num_errors++;
    $display("FAIL t=%0t %s", $time, msg);
  endtask

  task automatic check_val(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checks_done++;
    if (got !== exp)
      fail($sformatf("%s got %h exp %h", msg, got, exp));
  endtask

  task automatic final_report();
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // irq pulses and event hits as the design sees them
  always @(posedge ref_clk)
  begin
    irq_prev <= monitor_irq;
    if (!rst)
    begin
      if (monitor_irq === 1'b1 && irq_prev === 1'b1)
        fail("irq longer than one cycle");
      irq_cnt <= irq_cnt + monitor_irq;
      for (int i = 0; i < 4; i++)
        hits[i] <= hits[i] + event_hit[i];
    end
  end

  task automatic cycles(input integer n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic spr_write(input logic [9:0] num, input logic [31:0] data);
    @(posedge ref_clk);
    spr_req <= '{wr: 1'b1, rd: 1'b0, num: num, wdata: data};
    @(posedge ref_clk);
    spr_req.wr <= 1'b0;
  endtask

  task automatic spr_read(input logic [9:0] num, output logic [31:0] data);
    @(posedge ref_clk);
    spr_req <= '{wr: 1'b0, rd: 1'b1, num: num, wdata: 32'h0000_0000};
    @(posedge ref_clk);
    spr_req.rd <= 1'b0;
    // the answer launched at the taking edge is sampled at the next edge, inputs stay edge aligned
    @(posedge ref_clk);
    check_val({31'h0, spr_rvalid}, 32'h0000_0001, "rvalid");
    data = spr_rdata;
  endtask

  task automatic expect_reg(input logic [9:0] num, input logic [31:0] exp, input string msg);
    logic [31:0] got;
    spr_read(num, got);
    check_val(got, exp, msg);
  endtask

  task automatic wait_irq(input integer n);
    for (int i = 0; i < 200 && irq_cnt == n; i++)
      @(posedge ref_clk);
    if (irq_cnt == n)
    begin
      fail("no irq");
      final_report();
    end
  endtask

  task automatic freeze_case(input logic [31:0] ctrl, input logic u, input logic m, input logic frz);
    logic [31:0] base;
    logic [31:0] h0;
    base = {1'b0, 31'($random(seed))};
    spr_write(`PMC_SPR_CONTROL, ctrl);
    spr_write(cnum[0], base);
    h0 = hits[0];
    core_state <= '{user_state_bit: u, process_mark_bit: m};
    ev_en <= 4'hF;
    cycles(30);
    ev_en <= 4'h0;
    cycles(2);
    core_state <= '0;
    cycles(2);
    expect_reg(cnum[0], frz ? base : base + (hits[0] - h0), "count");
  endtask

  task automatic ovf_case(input logic [31:0] ctrl, input int idx, input logic cc, input logic f1, input logic f2);
    logic [31:0] v1;
    logic [31:0] v2;
    logic [31:0] h1;
    logic [31:0] h2;
    integer n;
    counter2_count_control <= cc;
    spr_write(`PMC_SPR_CONTROL, 32'h0000_0000);
    spr_write(cnum[0], 32'h0000_0000);
    spr_write(cnum[1], 32'h0000_0000);
    spr_write(cnum[idx], 32'h7FFF_FFFF);
    n = irq_cnt;
    spr_write(`PMC_SPR_CONTROL, ctrl);
    ev_en <= 4'hF;
    wait_irq(n);
    ev_en <= 4'h0;
    cycles(3);
    expect_reg(`PMC_SPR_CONTROL, ctrl & 32'hFBFF_FFFF, "enable cleared");
    spr_read(cnum[0], v1);
    spr_read(cnum[1], v2);
    h1 = hits[0];
    h2 = hits[1];
    n = irq_cnt;
    ev_en <= 4'hF;
    cycles(20);
    ev_en <= 4'h0;
    cycles(3);
    check_val(irq_cnt, n, "irq while disabled");
    expect_reg(cnum[0], f1 ? v1 : v1 + (hits[0] - h1), "c1 after irq");
    expect_reg(cnum[1], f2 ? v2 : v2 + (hits[1] - h2), "c2 after irq");
    // software re-arms the enable after service
    spr_write(`PMC_SPR_CONTROL, ctrl);
    cycles(4);
    check_val(irq_cnt, n + 1, "irq after re-arm");
  endtask

  task automatic tap_case(input logic [1:0] c, input int b, input logic on);
    logic [31:0] ctrl;
    integer n;
    ctrl = 32'h0400_0000 | (32'(on) << 22) | (32'(c) << 23);
    spr_write(`PMC_SPR_CONTROL, 32'h0000_0000);
    tb_step <= '0;
    tb_clr <= 1'b1;
    cycles(1);
    tb_clr <= 1'b0;
    n = irq_cnt;
    spr_write(`PMC_SPR_CONTROL, ctrl);
    tb_step <= 64'h1 << (b + 1);
    cycles(12);
    check_val(irq_cnt, n, "irq from unselected bit");
    tb_step <= 64'h1 << b;
    cycles(5);
    check_val(irq_cnt, n + on, "tap irq");
    expect_reg(`PMC_SPR_CONTROL, ctrl & ~(32'(on) << 26), "tap control");
    tb_step <= '0;
  endtask

  initial
  begin
    cycles(5);
    rst <= 1'b0;
    expect_reg(`PMC_SPR_CONTROL, `PMC_CONTROL_RESET, "control reset");
    for (int i = 0; i < 4; i++)
      expect_reg(cnum[i], `PMC_COUNTER_RESET, "counter reset");
    v = $random(seed) & 32'hFBFF_FFFF;
    spr_write(`PMC_SPR_CONTROL, v);
    expect_reg(`PMC_SPR_CONTROL, v, "readback");
    expect_reg(`PMC_SPR_CONTROL, v, "second read");
    core_state <= '{user_state_bit: 1'b1, process_mark_bit: 1'b0};
    expect_reg(`PMC_SPR_MIRROR, v, "user mirror");
    expect_reg(`PMC_SPR_CONTROL, 32'h0000_0000, "user read refused");
    spr_write(`PMC_SPR_CONTROL, ~v);
    core_state <= '0;
    expect_reg(`PMC_SPR_CONTROL, v, "user write ignored");
    expect_reg(10'h000, 32'h0000_0000, "unmapped read");
    // software load and readback of every counter, counters 3 and 4 included
    for (int i = 0; i < 4; i++)
    begin
      v = $random(seed) & 32'h0FFF_FFFF;
      spr_write(cnum[i], v);
      expect_reg(cnum[i], v, "counter load");
    end
    // start-up software clears the control register and the enable
    spr_write(`PMC_SPR_CONTROL, 32'h0000_0000);
    for (int k = 0; k < 10; k++)
      freeze_case(32'h1 << fpos[k], fuser[k], fmark[k], k % 2 == 0);
    ovf_case(32'h0640_8000, 0, 1'b0, 1'b1, 1'b1);
    ovf_case(32'h0600_4000, 1, 1'b1, 1'b1, 1'b0);
    ovf_case(32'h0400_8000, 0, 1'b0, 1'b0, 1'b0);
    tap_case(2'b00, 0, 1'b1);
    tap_case(2'b01, 8, 1'b1);
    tap_case(2'b10, 12, 1'b1);
    tap_case(2'b11, 16, 1'b1);
    tap_case(2'b10, 12, 1'b0);
    // software drops the enable left set by the last tap case
    spr_write(`PMC_SPR_CONTROL, 32'h0000_0000);
    final_report();
  end
endmodule
`default_nettype wire

// ### rtl/pmc_event_counter.sv
// one 32-bit event counter with hold and software load
`timescale 1ns/1ps
`default_nettype none
`include "pmc_regs.svh"
module pmc_event_counter
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic hold,
  input wire logic event_hit,
  input wire logic load,
  input wire logic [31:0] load_value,
  output logic [31:0] count
);

  logic [31:0] next_count;

  always_comb
  begin
    next_count = count;
    if (load)
    begin
      next_count = load_value;
    end
    else if (event_hit && !hold)
    begin
      // the top bit turns on as the count part carries past its maximum
      next_count = count + 32'h0000_0001;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      count <= `PMC_COUNTER_RESET;
    end
    else
    begin
      count <= next_count;
    end
  end

endmodule
`default_nettype wire

// ### rtl/pmc_monitor_control.sv
// performance monitor control: control register, freeze logic, counters and interrupt request
//
// Overview of operation
// - freeze_all set keeps every event counter from changing by hardware.
// - freeze_in_supervisor set holds counters while the core is in supervisor state.
// - freeze_in_user set holds counters while the core is in user state.
// - freeze_when_marked set holds counters while the process mark bit is one.
// - freeze_when_unmarked set holds counters while the process mark bit is zero.
// - monitor_irq_enable zero blocks every monitor interrupt.
// - signalling an interrupt clears monitor_irq_enable in the same update.
// - interrupt on enabled counter overflow or enabled time base tap rise with enable.
// - freeze_on_irq stops counter 1 after an interrupt; others too if count control zero.
// - with freeze_on_irq clear an interrupt leaves counting unaffected.
// - tap code 00,01,10,11 watches time base bit 63,55,51,47.
// - irq_on_timebase_tap set raises interrupt on each zero-to-one tap change.
// - hardware never alters irq_on_timebase_tap; only software writes do.
// - control register reachable only in supervisor state; user reads the mirror.
// - reading the control register has no side effects.
// - counter top bit marks overflow; the other bits hold the count.
// - bit 16 enables counter 1 overflow interrupt; bit 17 counters 2 to 4.
`timescale 1ns/1ps
`default_nettype none
`include "pmc_regs.svh"
module pmc_monitor_control
  import pmc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire pmc_spr_req_t spr_req,
  input wire pmc_core_state_t core_state,
  input wire logic [3:0] event_hit,
  input wire logic [63:0] time_base,
  input wire logic counter2_count_control,
  output logic [31:0] spr_rdata,
  output logic spr_rvalid,
  output logic monitor_irq
);

  logic [31:0] monitor_control_0;
  logic [31:0] next_monitor_control_0;
  logic irq_frozen;
  logic next_irq_frozen;
  logic tap_prev;
  logic next_tap_prev;
  logic [31:0] next_spr_rdata;
  logic next_spr_rvalid;
  logic next_monitor_irq;
  logic [31:0] event_counter [`PMC_NUM_COUNTERS];
  logic [`PMC_NUM_COUNTERS-1:0] counter_load;
  logic [`PMC_NUM_COUNTERS-1:0] counter_hold;
  logic supervisor;
  logic freeze_common;
  logic tap_bit;
  logic tap_rise;
  logic irq_cond;
  pmc_sel_t wr_sel;
  pmc_sel_t rd_sel;

  function automatic pmc_sel_t spr_decode(input logic [9:0] num);
    case (num)
      `PMC_SPR_CONTROL: spr_decode = PMC_SEL_CONTROL;
      `PMC_SPR_MIRROR: spr_decode = PMC_SEL_MIRROR;
      `PMC_SPR_COUNTER1: spr_decode = PMC_SEL_COUNTER1;
      `PMC_SPR_COUNTER2: spr_decode = PMC_SEL_COUNTER2;
      `PMC_SPR_COUNTER3: spr_decode = PMC_SEL_COUNTER3;
      `PMC_SPR_COUNTER4: spr_decode = PMC_SEL_COUNTER4;
      default: spr_decode = PMC_SEL_NONE;
    endcase
  endfunction

  function automatic logic [5:0] tap_index(input logic [1:0] code);
    case (code)
      2'b00: tap_index = `PMC_TAP_CODE0_BIT;
      2'b01: tap_index = `PMC_TAP_CODE1_BIT;
      2'b10: tap_index = `PMC_TAP_CODE2_BIT;
      default: tap_index = `PMC_TAP_CODE3_BIT;
    endcase
  endfunction

  // access decode; user state reaches only the mirror
  always_comb
  begin
    supervisor = !core_state.user_state_bit;
    wr_sel = PMC_SEL_NONE;
    rd_sel = PMC_SEL_NONE;
    if (spr_req.wr && supervisor && spr_decode(spr_req.num) != PMC_SEL_MIRROR)
    begin
      wr_sel = spr_decode(spr_req.num);
    end
    if (spr_req.rd && (supervisor || spr_decode(spr_req.num) == PMC_SEL_MIRROR))
    begin
      rd_sel = spr_decode(spr_req.num);
    end
  end

  // freeze conditions and time base tap
  always_comb
  begin
    freeze_common = monitor_control_0[`PMC_FREEZE_ALL_POS];
    freeze_common = freeze_common || (monitor_control_0[`PMC_FREEZE_IN_SUPERVISOR_POS] && supervisor);
    freeze_common = freeze_common || (monitor_control_0[`PMC_FREEZE_IN_USER_POS] && !supervisor);
    freeze_common = freeze_common || (monitor_control_0[`PMC_FREEZE_WHEN_MARKED_POS] && core_state.process_mark_bit);
    freeze_common = freeze_common
      || (monitor_control_0[`PMC_FREEZE_WHEN_UNMARKED_POS] && !core_state.process_mark_bit);
    counter_hold[0] = freeze_common || irq_frozen;
    counter_hold[1] = freeze_common || (irq_frozen && !counter2_count_control);
    counter_hold[2] = counter_hold[1];
    counter_hold[3] = counter_hold[1];
    tap_bit = time_base[tap_index(monitor_control_0[`PMC_TAP_SELECT_HI:`PMC_TAP_SELECT_LO])];
    next_tap_prev = tap_bit;
    tap_rise = tap_bit && !tap_prev;
  end

  // interrupt condition and control register update
  always_comb
  begin
    irq_cond = monitor_control_0[`PMC_MONITOR_IRQ_ENABLE_POS]
      && ((monitor_control_0[`PMC_COUNTER1_OVF_IRQ_POS] && event_counter[0][`PMC_COUNTER_OVF_POS])
      || (monitor_control_0[`PMC_COUNTERS234_OVF_IRQ_POS]
      && (event_counter[1][`PMC_COUNTER_OVF_POS] || event_counter[2][`PMC_COUNTER_OVF_POS]
      || event_counter[3][`PMC_COUNTER_OVF_POS]))
      || (monitor_control_0[`PMC_IRQ_ON_TAP_POS] && tap_rise));
    next_monitor_irq = irq_cond;
    next_monitor_control_0 = monitor_control_0;
    if (wr_sel == PMC_SEL_CONTROL)
    begin
      next_monitor_control_0 = spr_req.wdata;
    end
    if (irq_cond)
    begin
      next_monitor_control_0[`PMC_MONITOR_IRQ_ENABLE_POS] = 1'b0;
    end
    next_irq_frozen = irq_frozen;
    if (wr_sel == PMC_SEL_CONTROL)
    begin
      next_irq_frozen = 1'b0;
    end
    if (irq_cond && monitor_control_0[`PMC_FREEZE_ON_IRQ_POS])
    begin
      next_irq_frozen = 1'b1;
    end
  end

  // read path; reads change nothing
  always_comb
  begin
    next_spr_rvalid = spr_req.rd;
    case (rd_sel)
      PMC_SEL_CONTROL: next_spr_rdata = monitor_control_0;
      PMC_SEL_MIRROR: next_spr_rdata = monitor_control_0;
      PMC_SEL_COUNTER1: next_spr_rdata = event_counter[0];
      PMC_SEL_COUNTER2: next_spr_rdata = event_counter[1];
      PMC_SEL_COUNTER3: next_spr_rdata = event_counter[2];
      PMC_SEL_COUNTER4: next_spr_rdata = event_counter[3];
      default: next_spr_rdata = 32'h0000_0000;
    endcase
  end

  always_comb
  begin
    counter_load[0] = (wr_sel == PMC_SEL_COUNTER1);
    counter_load[1] = (wr_sel == PMC_SEL_COUNTER2);
    counter_load[2] = (wr_sel == PMC_SEL_COUNTER3);
    counter_load[3] = (wr_sel == PMC_SEL_COUNTER4);
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      monitor_control_0 <= `PMC_CONTROL_RESET;
      irq_frozen <= 1'b0;
      tap_prev <= 1'b0;
      spr_rdata <= 32'h0000_0000;
      spr_rvalid <= 1'b0;
      monitor_irq <= 1'b0;
    end
    else
    begin
      monitor_control_0 <= next_monitor_control_0;
      irq_frozen <= next_irq_frozen;
      tap_prev <= next_tap_prev;
      spr_rdata <= next_spr_rdata;
      spr_rvalid <= next_spr_rvalid;
      monitor_irq <= next_monitor_irq;
    end
  end

  for (genvar i = 0; i < `PMC_NUM_COUNTERS; i++)
  begin : g_counter
    pmc_event_counter u_counter
    (
      .ref_clk(ref_clk),
      .rst(rst),
      .hold(counter_hold[i]),
      .event_hit(event_hit[i]),
      .load(counter_load[i]),
      .load_value(spr_req.wdata),
      .count(event_counter[i])
    );
  end

  a_freeze_all_hold: assert property (@(posedge ref_clk) disable iff (rst)
    monitor_control_0[`PMC_FREEZE_ALL_POS] && !counter_load[0] |=> $stable(event_counter[0]))
    else $error("counter 1 changed under freeze_all");

  a_supervisor_hold: assert property (@(posedge ref_clk) disable iff (rst)
    monitor_control_0[`PMC_FREEZE_IN_SUPERVISOR_POS] && !core_state.user_state_bit && !counter_load[1]
    |=> $stable(event_counter[1]))
    else $error("counter 2 changed in supervisor freeze");

  a_user_hold: assert property (@(posedge ref_clk) disable iff (rst)
    monitor_control_0[`PMC_FREEZE_IN_USER_POS] && core_state.user_state_bit |=> $stable(event_counter[2]))
    else $error("counter 3 changed in user freeze");

  a_marked_hold: assert property (@(posedge ref_clk) disable iff (rst)
    monitor_control_0[`PMC_FREEZE_WHEN_MARKED_POS] && core_state.process_mark_bit && !counter_load[3]
    |=> $stable(event_counter[3]))
    else $error("counter 4 changed while marked");

  a_unmarked_hold: assert property (@(posedge ref_clk) disable iff (rst)
    monitor_control_0[`PMC_FREEZE_WHEN_UNMARKED_POS] && !core_state.process_mark_bit && !counter_load[0]
    |=> $stable(event_counter[0]))
    else $error("counter 1 changed while unmarked");

  a_irq_needs_enable: assert property (@(posedge ref_clk) disable iff (rst)
    monitor_irq |-> $past(monitor_control_0[`PMC_MONITOR_IRQ_ENABLE_POS]))
    else $error("interrupt without global enable");

  a_irq_clears_enable: assert property (@(posedge ref_clk) disable iff (rst)
    monitor_irq |-> !monitor_control_0[`PMC_MONITOR_IRQ_ENABLE_POS])
    else $error("enable still set after interrupt");

  a_ovf_irq: assert property (@(posedge ref_clk) disable iff (rst)
    monitor_control_0[`PMC_MONITOR_IRQ_ENABLE_POS] && monitor_control_0[`PMC_COUNTER1_OVF_IRQ_POS]
    && event_counter[0][`PMC_COUNTER_OVF_POS] |=> monitor_irq)
    else $error("counter 1 overflow not signalled");

  a_irq_freeze: assert property (@(posedge ref_clk) disable iff (rst)
    monitor_irq && $past(monitor_control_0[`PMC_FREEZE_ON_IRQ_POS]) && !counter_load[0]
    && !(wr_sel == PMC_SEL_CONTROL) |=> $stable(event_counter[0]))
    else $error("counter 1 moved after freezing interrupt");

  a_tap_bit_kept: assert property (@(posedge ref_clk) disable iff (rst)
    !(wr_sel == PMC_SEL_CONTROL) |=> $stable(monitor_control_0[`PMC_IRQ_ON_TAP_POS]))
    else $error("tap interrupt bit changed by hardware");

  a_user_no_write: assert property (@(posedge ref_clk) disable iff (rst)
    core_state.user_state_bit && !monitor_irq && !irq_cond |=> $stable(monitor_control_0))
    else $error("control changed from user state");

  a_irq_pulse: assert property (@(posedge ref_clk) disable iff (rst)
    monitor_irq |=> !monitor_irq)
    else $error("interrupt longer than one cycle");

endmodule
`default_nettype wire

// ### rtl/pmc_pkg.sv
// types shared by the performance monitor control block
package pmc_pkg;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [9:0] num;
    logic [31:0] wdata;
  } pmc_spr_req_t;

  typedef struct packed {
    logic user_state_bit;
    logic process_mark_bit;
  } pmc_core_state_t;

  typedef enum logic [2:0] {
    PMC_SEL_NONE,
    PMC_SEL_CONTROL,
    PMC_SEL_MIRROR,
    PMC_SEL_COUNTER1,
    PMC_SEL_COUNTER2,
    PMC_SEL_COUNTER3,
    PMC_SEL_COUNTER4
  } pmc_sel_t;

endpackage

// ### rtl/pmc_regs.svh
// register numbers, field positions and reset values of the performance monitor control block
`ifndef PMC_REGS_SVH
`define PMC_REGS_SVH

// special-register numbers
`define PMC_SPR_CONTROL 10'h3B8
`define PMC_SPR_MIRROR 10'h3A8
`define PMC_SPR_COUNTER1 10'h3B9
`define PMC_SPR_COUNTER2 10'h3BA
`define PMC_SPR_COUNTER3 10'h3BD
`define PMC_SPR_COUNTER4 10'h3BE

// control fields, as lsb-0 positions (msb-0 bit n sits at 31 - n)
`define PMC_FREEZE_ALL_POS 31
`define PMC_FREEZE_IN_SUPERVISOR_POS 30
`define PMC_FREEZE_IN_USER_POS 29
`define PMC_FREEZE_WHEN_MARKED_POS 28
`define PMC_FREEZE_WHEN_UNMARKED_POS 27
`define PMC_MONITOR_IRQ_ENABLE_POS 26
`define PMC_FREEZE_ON_IRQ_POS 25
`define PMC_TAP_SELECT_HI 24
`define PMC_TAP_SELECT_LO 23
`define PMC_IRQ_ON_TAP_POS 22
`define PMC_COUNTER1_OVF_IRQ_POS 15
`define PMC_COUNTERS234_OVF_IRQ_POS 14

// time base taps as lsb-0 indices of the 64-bit time base
`define PMC_TAP_CODE0_BIT 6'd0
`define PMC_TAP_CODE1_BIT 6'd8
`define PMC_TAP_CODE2_BIT 6'd12
`define PMC_TAP_CODE3_BIT 6'd16

`define PMC_CONTROL_RESET 32'h0000_0000
`define PMC_COUNTER_RESET 32'h0000_0000
`define PMC_COUNTER_OVF_POS 31
`define PMC_NUM_COUNTERS 4

`endif
